// ===== inc/decoder_status_irq_b_pkg.sv
// package: register map and constants for the status and interrupt B bank
package decoder_status_irq_b_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h1C;
   localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h1D;
   localparam logic [7:0] IDX_IRQ_POLARITY = 8'h1E;
   localparam logic [7:0] IDX_STD_SELECT   = 8'h28;
   localparam logic [7:0] IDX_CB_GAIN      = 8'h2C;
   localparam logic [7:0] IDX_CR_GAIN      = 8'h2D;
   localparam logic [7:0] IDX_CP_PRESENT   = 8'h2E;
   localparam logic [7:0] IDX_CP_ABSENT    = 8'h2F;
   localparam logic [7:0] IDX_PART_HIGH    = 8'h80;
   localparam logic [7:0] IDX_PART_LOW     = 8'h81;
   localparam logic [7:0] IDX_LINES_HIGH   = 8'h84;
   localparam logic [7:0] IDX_LINES_LOW    = 8'h85;
   localparam logic [7:0] IDX_IRQ_FLAGS    = 8'h86;
   localparam logic [7:0] IDX_IRQ_ACTIVE   = 8'h87;
   localparam logic [7:0] IDX_STATUS_ONE   = 8'h88;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_IRQ_ENABLE   = 8'h00;
   localparam logic       RST_POLARITY     = 1'b0;
   localparam logic [3:0] RST_STD_SELECT   = 4'h0;
   localparam logic [7:0] RST_CP_PRESENT   = 8'h0F;
   localparam logic [7:0] RST_CP_ABSENT    = 8'h01;
   localparam logic [7:0] RST_IRQ_FLAGS    = 8'h00;

   // arbitrary neutral identification value
   localparam logic [15:0] PART_CODE_DEFAULT = 16'hA5C3;

   // ------------------------------------------------------------
   // interrupt B flag positions
   // ------------------------------------------------------------
   localparam int FLAG_SW_INIT  = 7;
   localparam int FLAG_CP_CHG   = 6;
   localparam int FLAG_CMD_RDY  = 5;
   localparam int FLAG_FIELD    = 4;
   localparam int FLAG_LINE_ALT = 3;
   localparam int FLAG_COLOR    = 2;
   localparam int FLAG_HV_LOCK  = 1;
   localparam int FLAG_SOURCE   = 0;

   // ------------------------------------------------------------
   // standard select codes
   // ------------------------------------------------------------
   localparam logic [3:0] STD_AUTO     = 4'h0;
   localparam logic [3:0] STD_NTSC_M   = 4'h2;
   localparam logic [3:0] STD_PAL_BG   = 4'h4;
   localparam logic [3:0] STD_PAL_M    = 4'h6;
   localparam logic [3:0] STD_PAL_CN   = 4'h8;
   localparam logic [3:0] STD_NTSC_443 = 4'hA;
   localparam logic [3:0] STD_SECAM    = 4'hC;

endpackage

// ===== rtl/decoder_status_irq_b_regs.sv
// status, interrupt B and forced standard register bank behind an APB slave
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module decoder_status_irq_b_regs
   import decoder_status_irq_b_pkg::*;
#(
   parameter logic [15:0] PART_CODE = PART_CODE_DEFAULT
) (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // live state from the decoder core
   input  wire logic [7:0]  cb_gain,
   input  wire logic [7:0]  cr_gain,
   input  wire logic [9:0]  line_count,
   input  wire logic        color_locked,
   input  wire logic        vsync_locked,
   input  wire logic        hsync_locked,
   input  wire logic        peak_white,
   input  wire logic        line_alternating,
   input  wire logic        field_rate_50,
   input  wire logic        broadcast_or_tape_source,
   input  wire logic        sw_init_done,
   input  wire logic        cmd_ready,
   input  wire logic        frame_tick,
   input  wire logic        agc_pulses_seen,
   // standard control to the core
   output logic [3:0]       forced_std,
   output logic             std_forced,
   // interrupt B pin
   output logic             irq_b_out,
   output logic             irq_b_oe
);

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic [7:0] idx;
   logic       done;
   logic       wr;
   logic       rd;

   // register index from the word address
   assign idx  = paddr[9:2];
   assign done = psel & penable & pready & clk_en;
   assign wr   = done & pwrite;
   assign rd   = done & ~pwrite;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] irq_enable;
   logic       polarity;
   logic [3:0] std_select;
   logic [7:0] cp_present_frames;
   logic [7:0] cp_absent_frames;
   logic [7:0] flags;
   logic       irq_b;
   logic       lost_lock;
   logic       cp_detected;
   logic [7:0] cp_run;
   logic [5:0] prev_live;
   logic       prev_init;
   logic [7:0] next_flags;
   logic [7:0] set_ev;
   logic [5:0] live;
   logic [7:0] cp_limit;
   logic       cp_differs;
   logic       cp_flip;
   logic       std_valid;
   logic [31:0] rd_val;
   logic       mapped;

   // ------------------------------------------------------------
   // writable configuration
   // ------------------------------------------------------------
   // enable mask, reserved bit 5 never stored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_enable <= RST_IRQ_ENABLE;
      end else if (wr && idx == IDX_IRQ_ENABLE) begin
         irq_enable <= pwdata[7:0] & 8'hDF;
      end
   end

   // polarity, only bit 0 is kept
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         polarity <= RST_POLARITY;
      end else if (wr && idx == IDX_IRQ_POLARITY) begin
         polarity <= pwdata[0];
      end
   end

   // standard select, upper nibble reserved
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         std_select <= RST_STD_SELECT;
      end else if (wr && idx == IDX_STD_SELECT) begin
         std_select <= pwdata[3:0];
      end
   end

   // frame thresholds for the protection detector
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cp_present_frames <= RST_CP_PRESENT;
         cp_absent_frames  <= RST_CP_ABSENT;
      end else if (wr && idx == IDX_CP_PRESENT) begin
         cp_present_frames <= pwdata[7:0];
      end else if (wr && idx == IDX_CP_ABSENT) begin
         cp_absent_frames <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // forced standard
   // ------------------------------------------------------------
   // reserved codes fall back to autoswitch in the core
   always_comb begin
      case (std_select)
         STD_NTSC_M, STD_PAL_BG, STD_PAL_M, STD_PAL_CN, STD_NTSC_443, STD_SECAM:
            std_valid = 1'b1;
         default:
            std_valid = 1'b0;
      endcase
   end

   // registered so the core sees a glitch-free code
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         forced_std <= STD_AUTO;
         std_forced <= 1'b0;
      end else if (clk_en) begin
         forced_std <= std_valid ? std_select : STD_AUTO;
         std_forced <= std_valid;
      end
   end

   // ------------------------------------------------------------
   // copy-protection frame counting
   // ------------------------------------------------------------
   // a zero threshold behaves as one frame
   assign cp_limit   = cp_detected ? cp_absent_frames : cp_present_frames;
   assign cp_differs = agc_pulses_seen != cp_detected;
   assign cp_flip    = frame_tick & cp_differs & ((cp_run + 8'h01) >= cp_limit);

   // run of consecutive frames disagreeing with the verdict
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cp_run      <= 8'h00;
         cp_detected <= 1'b0;
      end else if (clk_en && frame_tick) begin
         if (!cp_differs) begin
            cp_run <= 8'h00; // any agreeing frame breaks the run
         end else if (cp_flip) begin
            cp_run      <= 8'h00;
            cp_detected <= ~cp_detected;
         end else if (cp_run != 8'hFF) begin
            cp_run <= cp_run + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // change detection, sticky flags and the command ready level bit
   // ------------------------------------------------------------
   // live conditions watched for change
   assign live = {cp_detected, field_rate_50, line_alternating,
                  color_locked, hsync_locked & vsync_locked,
                  broadcast_or_tape_source};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_live <= 6'h00;
         prev_init <= 1'b0;
      end else if (clk_en) begin
         prev_live <= live;
         prev_init <= sw_init_done;
      end
   end

   // events raise flags whatever the mask says
   always_comb begin
      set_ev = 8'h00;
      set_ev[FLAG_SW_INIT]  = sw_init_done & ~prev_init;
      set_ev[FLAG_CP_CHG]   = live[5] ^ prev_live[5];
      set_ev[FLAG_FIELD]    = live[4] ^ prev_live[4];
      set_ev[FLAG_LINE_ALT] = live[3] ^ prev_live[3];
      set_ev[FLAG_COLOR]    = live[2] ^ prev_live[2];
      set_ev[FLAG_HV_LOCK]  = live[1] ^ prev_live[1];
      set_ev[FLAG_SOURCE]   = live[0] ^ prev_live[0];
   end

   // clear by writing ones, a same-cycle event wins
   always_comb begin
      next_flags = flags;
      if (wr && idx == IDX_IRQ_CLEAR) begin
         next_flags = flags & ~pwdata[7:0];
      end
      next_flags = next_flags | set_ev;
      next_flags[FLAG_CMD_RDY] = cmd_ready;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags <= RST_IRQ_FLAGS;
      end else if (clk_en) begin
         flags <= next_flags;
      end
   end

   // lost lock: sticky until status one is read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lost_lock <= 1'b0;
      end else if (clk_en) begin
         if (prev_live[1] && !live[1]) begin
            lost_lock <= 1'b1;
         end else if (rd && idx == IDX_STATUS_ONE) begin
            lost_lock <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt pin
   // ------------------------------------------------------------
   // the mask touches only the pin path and the active bit, never the flags
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_b <= 1'b0;
      end else if (clk_en) begin
         irq_b <= |(flags & irq_enable);
      end
   end

   // open drain when active low, push-pull when active high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_b_out <= 1'b0;
         irq_b_oe  <= 1'b0;
      end else if (clk_en) begin
         if (polarity) begin
            irq_b_out <= |(flags & irq_enable);
            irq_b_oe  <= 1'b1;
         end else begin
            irq_b_out <= 1'b0;
            irq_b_oe  <= |(flags & irq_enable);
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   // unmapped indices answer with an error and zero data
   always_comb begin
      rd_val = 32'h0000_0000;
      mapped = 1'b1;
      if (idx == IDX_IRQ_CLEAR) begin
         rd_val = 32'h0000_0000;
      end else if (idx == IDX_IRQ_ENABLE) begin
         rd_val[7:0] = irq_enable;
      end else if (idx == IDX_IRQ_POLARITY) begin
         rd_val[0] = polarity;
      end else if (idx == IDX_STD_SELECT) begin
         rd_val[3:0] = std_select;
      end else if (idx == IDX_CB_GAIN) begin
         rd_val[7:0] = cb_gain;
      end else if (idx == IDX_CR_GAIN) begin
         rd_val[7:0] = cr_gain;
      end else if (idx == IDX_CP_PRESENT) begin
         rd_val[7:0] = cp_present_frames;
      end else if (idx == IDX_CP_ABSENT) begin
         rd_val[7:0] = cp_absent_frames;
      end else if (idx == IDX_PART_HIGH) begin
         rd_val[7:0] = PART_CODE[15:8];
      end else if (idx == IDX_PART_LOW) begin
         rd_val[7:0] = PART_CODE[7:0];
      end else if (idx == IDX_LINES_HIGH) begin
         rd_val[1:0] = line_count[9:8];
      end else if (idx == IDX_LINES_LOW) begin
         rd_val[7:0] = line_count[7:0];
      end else if (idx == IDX_IRQ_FLAGS) begin
         rd_val[7:0] = flags;
      end else if (idx == IDX_IRQ_ACTIVE) begin
         rd_val[0] = irq_b;
      end else if (idx == IDX_STATUS_ONE) begin
         rd_val[7:0] = {peak_white, line_alternating, field_rate_50,
                        lost_lock, color_locked, vsync_locked,
                        hsync_locked, broadcast_or_tape_source};
      end else begin
         mapped = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // apb answer: one wait state, data captured with pready
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= ~mapped;
         end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   low_release_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && !polarity |=> !irq_b_out && (irq_b_oe == $past(|(flags & irq_enable))))
      else $error("active-low pin not open drain");

   high_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && polarity |=> irq_b_oe && (irq_b_out == $past(|(flags & irq_enable))))
      else $error("active-high pin not push-pull");

   force_std_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && std_select == STD_SECAM |=> std_forced && forced_std == STD_SECAM)
      else $error("forced standard not applied");

   clear_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && wr && idx == IDX_IRQ_CLEAR && !pwdata[FLAG_COLOR] && flags[FLAG_COLOR]
      |=> flags[FLAG_COLOR])
      else $error("flag lost on zero clear bit");

   clear_one_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && wr && idx == IDX_IRQ_CLEAR && pwdata[FLAG_FIELD] && !set_ev[FLAG_FIELD]
      |=> !flags[FLAG_FIELD])
      else $error("flag not cleared by one");

   sticky_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      flags[FLAG_SOURCE] && !(wr && idx == IDX_IRQ_CLEAR) |=> flags[FLAG_SOURCE])
      else $error("flag dropped without clear");

   mask_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && (flags & irq_enable) != 8'h00 |=> irq_b)
      else $error("enabled flag did not raise pin");

   lost_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      rd && idx == IDX_STATUS_ONE && !(prev_live[1] && !live[1]) |=> !lost_lock)
      else $error("lost lock not cleared by read");

   cp_on_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && frame_tick && !cp_detected && agc_pulses_seen
      && cp_present_frames > 8'h01 && cp_run == 8'h00 |=> !cp_detected)
      else $error("protection declared too early");

   cmd_level_a: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en |=> flags[FLAG_CMD_RDY] == $past(cmd_ready))
      else $error("command ready bit wrong");

endmodule // decoder_status_irq_b_regs

// ===== verification/irq_pin_host.sv
// host side model: resolves the interrupt pin and reads it
`timescale 1ns/100ps
module irq_pin_host (
   // pin drive from the bank
   input  wire logic irq_b_out,
   input  wire logic irq_b_oe,
   // polarity the host keeps for interrupt A
   input  wire logic pol_a,
   // resolved pin and host view
   output logic      pin,
   output logic      host_irq
);
   // a released pin floats to the board pull-up, never the last driven level
   assign pin = irq_b_oe ? irq_b_out : 1'b1;
   // host decodes the pin with its own polarity setting
   assign host_irq = pol_a ? pin : ~pin;
endmodule // irq_pin_host

// ===== verification/decoder_status_irq_b_regs_test.sv
// self-checking bench for the status and interrupt B register bank
`timescale 1ns/100ps
module decoder_status_irq_b_regs_test import decoder_status_irq_b_pkg::*;;
   // arbitrary part code, differs from the package default on purpose
   localparam logic [15:0] CODE = 16'h3C96;
   logic        clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [9:0]  paddr, line_count;
   logic [31:0] pwdata, prdata;
   logic [7:0]  cb_gain, cr_gain;
   logic        color_locked, vsync_locked, hsync_locked, peak_white, line_alternating;
   logic        field_rate_50, broadcast_or_tape_source, sw_init_done, cmd_ready;
   logic        frame_tick, agc_pulses_seen, std_forced, irq_b_out, irq_b_oe;
   logic        pin, host_irq, pol_a, ok;
   logic [3:0]  forced_std;
   logic [32:0] exp_q[$];
   int          error_cnt, total_checks, cycles;
   int          seed = 32'h1FB7;
   logic [7:0]  rst_idx[10] = '{8'h1C, 8'h1D, 8'h1E, 8'h28, 8'h2E, 8'h2F, 8'h80, 8'h81, 8'h86, 8'h87};
   logic [7:0]  rst_val[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h01, 8'h3C, 8'h96, 8'h00, 8'h00};

   decoder_status_irq_b_regs #(.PART_CODE(CODE)) u_decoder_status_irq_b_regs (
      .clk, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .cb_gain, .cr_gain, .line_count, .color_locked, .vsync_locked, .hsync_locked,
      .peak_white, .line_alternating, .field_rate_50, .broadcast_or_tape_source, .sw_init_done,
      .cmd_ready, .frame_tick, .agc_pulses_seen, .forced_std, .std_forced, .irq_b_out, .irq_b_oe);

   irq_pin_host u_irq_pin_host (.irq_b_out, .irq_b_oe, .pol_a, .pin, .host_irq);

   // ------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      total_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // pin nibble is {oe, out, resolved pin, host sees asserted}
   task automatic pin_is(input logic [3:0] e);
      check(33'({irq_b_oe, irq_b_out, pin, host_irq}), 33'(e));
   endtask

   // ------------------------------------------------------------
   // bus and stimulus tasks
   // ------------------------------------------------------------
   // one idle edge first so no signal is assigned twice in a time step
   // waits as long as the slave needs; only the hang guard ends a stuck wait
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] e);
      @(posedge clk);
      if (!wr) exp_q.push_back(e);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b0, idx, 32'h0, {25'h0, v});
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         frame_tick <= 1'b1;
         @(posedge clk);
         frame_tick <= 1'b0;
      end
   endtask

   // clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // read answers: oldest note against each completed read
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) check(33'h1, 33'h0);
         else check({pslverr, prdata}, exp_q.pop_front());
      end
   end

   // hang guard, well above the length of the sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst <= 1'b1;
      clk_en  <= 1'b1;
      {psel, penable, pwrite, paddr, pwdata, cb_gain, cr_gain, line_count} <= '0;
      {color_locked, vsync_locked, hsync_locked, peak_white, line_alternating} <= '0;
      {field_rate_50, broadcast_or_tape_source, sw_init_done, cmd_ready} <= '0;
      {frame_tick, agc_pulses_seen, pol_a} <= '0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 10; i++) rd(rst_idx[i], rst_val[i]);
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      pin_is(4'b0010);
      // live readback; writes to the read-only Cb gain must not stick
      for (int i = 0; i < 3; i++) begin
         cb_gain    <= 8'($random(seed));
         cr_gain    <= 8'($random(seed));
         line_count <= 10'($random(seed));
         wr(8'h2C, 32'hFF);
         rd(8'h2C, cb_gain);
         rd(8'h2D, cr_gain);
         rd(8'h84, {6'h0, line_count[9:8]});
         rd(8'h85, line_count[7:0]);
      end
      wr(8'h1E, 32'hFFFF_FFFE);
      rd(8'h1E, 8'h00);
      // every standard code, reserved ones included
      for (int c = 0; c < 16; c++) begin
         wr(8'h28, {28'hFFF_FFFF, 4'(c)});
         rd(8'h28, {4'h0, 4'(c)});
         ok = (c != 0) && (c % 2 == 0) && (c <= 12);
         check(33'({std_forced, forced_std}), 33'({ok, ok ? 4'(c) : 4'h0}));
      end
      wr(8'h1D, 32'hFF);
      rd(8'h1D, 8'hDF);
      color_locked <= 1'b1;
      rd(8'h86, 8'h04);
      rd(8'h87, 8'h01);
      pin_is(4'b1001);
      wr(8'h1C, 32'hFB);
      rd(8'h86, 8'h04);
      wr(8'h1C, 32'h04);
      rd(8'h86, 8'h00);
      rd(8'h87, 8'h00);
      pin_is(4'b0010);
      wr(8'h1E, 32'h01);
      pol_a <= 1'b1;
      rd(8'h1E, 8'h01);
      pin_is(4'b1000);
      color_locked <= 1'b0;
      rd(8'h86, 8'h04);
      pin_is(4'b1111);
      wr(8'h1C, 32'hFF);
      rd(8'h86, 8'h00);
      pin_is(4'b1000);
      // masked source still flags, pin stays quiet
      wr(8'h1D, 32'h00);
      field_rate_50 <= 1'b1;
      rd(8'h86, 8'h10);
      rd(8'h87, 8'h00);
      pin_is(4'b1000);
      wr(8'h1C, 32'hFF);
      {sw_init_done, line_alternating, broadcast_or_tape_source} <= 3'h7;
      {hsync_locked, vsync_locked, cmd_ready, peak_white} <= 4'hF;
      rd(8'h86, 8'hAB);
      rd(8'h88, 8'hE7);
      cmd_ready <= 1'b0;
      wr(8'h1C, 32'hFF);
      rd(8'h86, 8'h00);
      vsync_locked <= 1'b0;
      rd(8'h88, 8'hF3);
      rd(8'h88, 8'hE3);
      rd(8'h86, 8'h02);
      wr(8'h1C, 32'hFF);
      // copy-protection verdict thresholds
      wr(8'h2E, 32'h03);
      rd(8'h2E, 8'h03);
      wr(8'h2F, 32'h02);
      rd(8'h2F, 8'h02);
      agc_pulses_seen <= 1'b1;
      tick(2);
      rd(8'h86, 8'h00);
      tick(1);
      rd(8'h86, 8'h40);
      wr(8'h1C, 32'hFF);
      agc_pulses_seen <= 1'b0;
      tick(1);
      rd(8'h86, 8'h00);
      tick(1);
      rd(8'h86, 8'h40);
      // enable low freezes change detection: a pulse and its undo go unseen
      clk_en       <= 1'b0;
      color_locked <= 1'b1;
      repeat (3) @(posedge clk);
      color_locked <= 1'b0;
      @(posedge clk);
      clk_en       <= 1'b1;
      rd(8'h86, 8'h40);
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule // decoder_status_irq_b_regs_test
